//--- sbg_cfg.svh
// Contract
// RULE1: divisor is high register bits 4:0 above low register bits 7:0, thirteen bits.
// RULE2: high register write is only buffered; working high bits load on low write.
// RULE3: software writes high register first, then low register, to change divisor.
// RULE4: a zero divisor stops the generator completely; no baud timing is produced.
// RULE5: divisor one to 8191 gives baud rate equal to bus clock over sixteen times divisor.
// RULE6: low register resets non-zero, yet generator idles until receiver or transmitter enabled.
// RULE7: high register bit 7 lets the break-detect flag request an interrupt.
// RULE8: high register bit 6 lets the receive-edge flag request an interrupt.
// RULE9: modulo counter emits one oversampling pulse every divisor cycles, then reloads.
`ifndef SBG_CFG_SVH
`define SBG_CFG_SVH

`define SBG_ADDR_W      3
`define SBG_DATA_W      8
`define SBG_DIV_W       13
`define SBG_HI_W        5

`define SBG_OFS_BDH     3'h0
`define SBG_OFS_BDL     3'h1
`define SBG_OFS_CTRL    3'h2
`define SBG_OFS_STAT    3'h3
`define SBG_OFS_STATE   3'h4

`define SBG_BDH_BRKIE   7
`define SBG_BDH_EDGIE   6
`define SBG_BDH_HI_MSB  4
`define SBG_CTRL_TE     3
`define SBG_CTRL_RE     2
`define SBG_STAT_BRK    7
`define SBG_STAT_EDG    6
`define SBG_STATE_RUN   0
`define SBG_STATE_ARMED 1

`define SBG_BDH_RST     8'h00
`define SBG_BDL_RST     8'h04
`define SBG_CTRL_RST    8'h00
`define SBG_DIV_ZERO    13'h0000
`define SBG_DIV_ONE     13'h0001

`define SBG_OVS_W       4
`define SBG_OVS_LAST    4'hf

`endif

//--- sbg_counter.sv
`timescale 1ns/1ps
`include "sbg_cfg.svh"

module sbg_counter
    import sbg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        run,
    input  wire logic [12:0] divisor,
    output logic             tick
);

    sbg_cnt_st_t st_r;
    sbg_cnt_st_t st_nxt;

    // modulo count, one pulse per divisor cycles
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (!run) begin
            st_nxt.cnt = `SBG_DIV_ZERO;
        end else if (st_r.cnt >= divisor - `SBG_DIV_ONE) begin // see RULE9
            st_nxt.cnt  = `SBG_DIV_ZERO;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + `SBG_DIV_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // hold a pending pulse back once run drops, so a stopped generator shows none
    assign tick = st_r.tick && run; // see RULE4

endmodule : sbg_counter

//--- sbg_line_model.sv
`timescale 1ns/1ps

module sbg_line_model (
    input  wire logic clk,
    input  wire logic send_break,
    input  wire logic send_edge,
    output logic      brk_evt,
    output logic      edg_evt
);
    // receiver side: one-cycle events on the bus clock
    always_ff @(posedge clk) begin
        brk_evt <= send_break;
        edg_evt <= send_edge;
    end
endmodule : sbg_line_model

//--- sbg_pkg.sv
package sbg_pkg;

    typedef enum logic [1:0] {
        SBG_IDLE = 2'b00,
        SBG_STOP = 2'b01,
        SBG_RUN  = 2'b10
    } sbg_gen_t;

    typedef struct packed {
        logic [12:0] cnt;
        logic        tick;
    } sbg_cnt_st_t;

    typedef struct packed {
        logic [7:0] bdh_buf;
        logic [4:0] hi_work;
        logic [7:0] bdl;
        logic       re;
        logic       te;
        logic       brk_flag;
        logic       edg_flag;
        sbg_gen_t   gen;
        logic [3:0] phase;
        logic       bit_tick;
        logic [7:0] rdata;
    } sbg_regs_t;

endpackage : sbg_pkg

//--- sbg_top.sv
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "sbg_cfg.svh"

module sbg_top
    import sbg_pkg::*;
(
    input  wire logic                   CLK_SYS,
    input  wire logic                   NRST,
    input  wire logic [`SBG_ADDR_W-1:0] ADDR,
    input  wire logic [`SBG_DATA_W-1:0] WDATA,
    input  wire logic                   WR,
    input  wire logic                   RD,
    output logic      [`SBG_DATA_W-1:0] RDATA,
    input  wire logic                   BREAK_DET,
    input  wire logic                   RX_EDGE,
    output logic                        RX_ENABLE,
    output logic                        TX_ENABLE,
    output logic                        BAUD_TICK,
    output logic                        BAUD_BIT,
    output logic                        BAUD_ACTIVE,
    output logic                        IRQ
);

    sbg_regs_t             r_r;
    sbg_regs_t             r_nxt;
    logic [`SBG_DIV_W-1:0] div_work;
    logic [`SBG_DIV_W-1:0] div_next;
    logic                  tick;
    logic                  wr_bdh;
    logic                  wr_bdl;
    logic                  wr_ctrl;
    logic                  wr_stat;
    logic                  arm_wr;

    localparam logic [7:0] ctrl_rst = `SBG_CTRL_RST;

    assign wr_bdh  = WR && (ADDR == `SBG_OFS_BDH);
    assign wr_bdl  = WR && (ADDR == `SBG_OFS_BDL);
    assign wr_ctrl = WR && (ADDR == `SBG_OFS_CTRL);
    assign wr_stat = WR && (ADDR == `SBG_OFS_STAT);
    assign arm_wr  = wr_ctrl && (WDATA[`SBG_CTRL_RE] || WDATA[`SBG_CTRL_TE]);

    // working divisor from working high bits and low register
    assign div_work = {r_r.hi_work, r_r.bdl}; // see RULE1

    always_comb begin
        r_nxt = r_r;
        r_nxt.bit_tick = 1'b0;
        r_nxt.rdata    = 8'h00;

        // high half only lands in the buffer
        if (wr_bdh) begin
            r_nxt.bdh_buf = WDATA; // see RULE2
        end
        // low write commits buffered high bits together with low bits
        if (wr_bdl) begin
            r_nxt.bdl     = WDATA; // see RULE1
            r_nxt.hi_work = r_r.bdh_buf[`SBG_BDH_HI_MSB:0]; // see RULE2
        end
        if (wr_ctrl) begin
            r_nxt.re = WDATA[`SBG_CTRL_RE];
            r_nxt.te = WDATA[`SBG_CTRL_TE];
        end

        // sticky flags, write one to clear, a new event wins
        if (wr_stat && WDATA[`SBG_STAT_BRK]) begin
            r_nxt.brk_flag = 1'b0;
        end
        if (wr_stat && WDATA[`SBG_STAT_EDG]) begin
            r_nxt.edg_flag = 1'b0;
        end
        if (BREAK_DET) begin
            r_nxt.brk_flag = 1'b1;
        end
        if (RX_EDGE) begin
            r_nxt.edg_flag = 1'b1;
        end

        div_next = {r_nxt.hi_work, r_nxt.bdl};

        // generator state: idle after reset until first enable
        case (r_r.gen)
            SBG_IDLE: begin
                if (arm_wr) begin // see RULE6
                    r_nxt.gen = (div_next == `SBG_DIV_ZERO) ? SBG_STOP : SBG_RUN;
                end
            end
            SBG_RUN: begin
                if (div_next == `SBG_DIV_ZERO) begin // see RULE4
                    r_nxt.gen = SBG_STOP;
                end
            end
            SBG_STOP: begin
                if (div_next != `SBG_DIV_ZERO) begin
                    r_nxt.gen = SBG_RUN;
                end
            end
            default: begin
                r_nxt.gen = SBG_IDLE;
            end
        endcase

        // sixteen oversampling pulses make one bit time
        if (r_r.gen != SBG_RUN) begin
            r_nxt.phase = '0;
        end else if (tick) begin
            r_nxt.phase = r_r.phase + 4'h1; // see RULE5
            if (r_r.phase == `SBG_OVS_LAST) begin
                r_nxt.bit_tick = 1'b1; // see RULE5
            end
        end

        // read data, valid in the cycle after the strobe
        if (RD) begin
            case (ADDR)
                `SBG_OFS_BDH: begin
                    r_nxt.rdata = r_r.bdh_buf & 8'hdf;
                end
                `SBG_OFS_BDL: begin
                    r_nxt.rdata = r_r.bdl;
                end
                `SBG_OFS_CTRL: begin
                    r_nxt.rdata[`SBG_CTRL_RE] = r_r.re;
                    r_nxt.rdata[`SBG_CTRL_TE] = r_r.te;
                end
                `SBG_OFS_STAT: begin
                    r_nxt.rdata[`SBG_STAT_BRK] = r_r.brk_flag;
                    r_nxt.rdata[`SBG_STAT_EDG] = r_r.edg_flag;
                end
                `SBG_OFS_STATE: begin
                    r_nxt.rdata[`SBG_STATE_RUN]   = (r_r.gen == SBG_RUN);
                    r_nxt.rdata[`SBG_STATE_ARMED] = (r_r.gen != SBG_IDLE);
                end
                default: begin
                    r_nxt.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            r_r          <= '0;
            r_r.bdh_buf  <= `SBG_BDH_RST;
            r_r.bdl      <= `SBG_BDL_RST; // see RULE6
            r_r.re       <= ctrl_rst[`SBG_CTRL_RE];
            r_r.te       <= ctrl_rst[`SBG_CTRL_TE];
            r_r.gen      <= SBG_IDLE;
        end else begin
            r_r <= r_nxt;
        end
    end

    sbg_counter u_counter (
        .clk     (CLK_SYS),
        .nrst    (NRST),
        .run     (r_r.gen == SBG_RUN), // see RULE4
        .divisor (div_work),
        .tick    (tick)
    );

    assign RDATA       = r_r.rdata;
    assign RX_ENABLE   = r_r.re;
    assign TX_ENABLE   = r_r.te;
    assign BAUD_TICK   = tick;
    assign BAUD_BIT    = r_r.bit_tick;
    assign BAUD_ACTIVE = (r_r.gen == SBG_RUN);
    // enables in the high register act as the interrupt mask
    assign IRQ = (r_r.brk_flag && r_r.bdh_buf[`SBG_BDH_BRKIE])  // see RULE7
              || (r_r.edg_flag && r_r.bdh_buf[`SBG_BDH_EDGIE]); // see RULE8

    // helper logic for the checks below
    logic [12:0] gap_r;
    logic        seen_r;
    logic [12:0] div_prev_r;

    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            gap_r      <= 13'h0001;
            seen_r     <= 1'b0;
            div_prev_r <= 13'h0000;
        end else begin
            div_prev_r <= div_work;
            if (!BAUD_ACTIVE || div_work != div_prev_r) begin
                seen_r <= 1'b0;
                gap_r  <= 13'h0001;
            end else if (tick) begin
                seen_r <= 1'b1;
                gap_r  <= 13'h0001;
            end else begin
                gap_r <= gap_r + 13'h0001;
            end
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);

    a_div_join: assert property ( // see RULE1
        wr_bdl |=> div_work == {$past(r_r.bdh_buf[4:0]), $past(WDATA)})
        else $error("divisor not formed from high buffer and low write");

    a_high_buffered: assert property ( // see RULE2
        (wr_bdh && !wr_bdl) |=> $stable(div_work))
        else $error("high write changed the working divisor");

    a_zero_div_off: assert property ( // see RULE4
        (div_work == 13'h0000) |-> (!BAUD_ACTIVE && !tick) ##1 !tick)
        else $error("generator active with zero divisor");

    a_bit_sixteen: assert property ( // see RULE5
        BAUD_BIT |-> $past(tick) && $past(r_r.phase) == 4'hf)
        else $error("bit pulse not on sixteenth tick");

    a_idle_until_en: assert property ( // see RULE6
        (r_r.gen == SBG_IDLE && !arm_wr) |=> !BAUD_ACTIVE ##1 !tick)
        else $error("generator ran before any enable");

    a_break_irq: assert property ( // see RULE7
        (r_r.brk_flag && r_r.bdh_buf[7]) |-> IRQ)
        else $error("break flag enabled but no interrupt");

    a_edge_irq: assert property ( // see RULE8
        (r_r.edg_flag && r_r.bdh_buf[6]) |-> IRQ)
        else $error("edge flag enabled but no interrupt");

    a_irq_cause: assert property ( // see RULE7
        IRQ |-> (r_r.brk_flag && r_r.bdh_buf[7]) || (r_r.edg_flag && r_r.bdh_buf[6]))
        else $error("interrupt without an enabled flag");

    a_tick_period: assert property ( // see RULE9
        (tick && seen_r && $stable(div_work)) |-> gap_r == div_work)
        else $error("oversampling pulse spacing differs from divisor");

    a_flag_set_wins: assert property ( // see RULE7
        (BREAK_DET && wr_stat && WDATA[7]) |=> r_r.brk_flag)
        else $error("break event lost on clear");

    c_run_start: cover property (r_r.gen == SBG_IDLE ##1 BAUD_ACTIVE);
    c_bit_time:  cover property (BAUD_BIT);
    c_stop_zero: cover property (BAUD_ACTIVE ##1 r_r.gen == SBG_STOP);
    c_irq_seen:  cover property (!IRQ ##1 IRQ);

endmodule : sbg_top

//--- tb.sv
`timescale 1ns/1ps
`include "sbg_cfg.svh"

module tb;
    logic        clk_sys = 1'b0;
    logic        nrst    = 1'b0;
    logic [2:0]  addr    = 3'h0;
    logic [7:0]  wdata   = 8'h00;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic [1:0]  req     = 2'h0;
    logic [7:0]  rdata;
    logic        brk_evt, edg_evt, rx_en, tx_en, tick, bit_p, active, irq;
    int          fails   = 0;
    int          checks  = 0;
    int          cycles  = 0;
    int          ticks   = 0;
    int          t0;
    logic [18:0] rows [5] = '{{3'h0, 8'hff, 8'hdf}, {3'h1, 8'h5a, 8'h5a},
                              {3'h2, 8'h00, 8'h00}, {3'h5, 8'hff, 8'h00},
                              {3'h4, 8'hff, 8'h00}};

    sbg_top i_dut (.CLK_SYS(clk_sys), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .BREAK_DET(brk_evt), .RX_EDGE(edg_evt), .RX_ENABLE(rx_en),
        .TX_ENABLE(tx_en), .BAUD_TICK(tick), .BAUD_BIT(bit_p), .BAUD_ACTIVE(active), .IRQ(irq));

    sbg_line_model i_line (.clk(clk_sys), .send_break(req[0]), .send_edge(req[1]),
        .brk_evt(brk_evt), .edg_evt(edg_evt));

    initial begin
        forever #20 clk_sys = ~clk_sys;
    end

    task report_and_stop;
        if (fails == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask : wreg

    task rreg(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        rd <= 1'b1; addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        @(negedge clk_sys);
        chk("rdata", {8'h00, exp}, {8'h00, rdata});
        @(negedge clk_sys);
        chk("rdata after read", 16'h0000, {8'h00, rdata});
    endtask : rreg

    // skip to one pulse, then count cycles to the next
    task per(input logic sel, input logic [15:0] exp);
        logic [15:0] n;
        repeat (2) begin
            n = 16'h0000;
            do begin
                @(negedge clk_sys);
                n++;
            end while ((sel ? bit_p : tick) !== 1'b1 && n < 16'h2328);
        end
        chk(sel ? "bit period" : "tick period", exp, n);
    endtask : per

    task pulse(input int k);
        @(posedge clk_sys);
        req[k] <= 1'b1;
        @(posedge clk_sys);
        req[k] <= 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask : pulse

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (tick === 1'b1) ticks <= ticks + 1;
        if (cycles == 40000) begin
            fails++;
            report_and_stop;
        end
    end

    initial begin
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        @(negedge clk_sys);
        chk("idle outputs", 16'h0000, {11'h000, rx_en, tx_en, tick, active, irq});
        rreg(`SBG_OFS_BDH, 8'h00);
        rreg(`SBG_OFS_BDL, 8'h04);
        for (int i = 0; i < 5; i++) begin
            wreg(rows[i][18:16], rows[i][15:8]);
            rreg(rows[i][18:16], rows[i][7:0]);
        end
        // events polled with enable clear, then raised, then cleared
        for (int k = 0; k < 2; k++) begin
            wreg(`SBG_OFS_BDH, 8'h00);
            wreg(`SBG_OFS_BDL, 8'h04);
            pulse(k);
            chk("irq masked", 16'h0000, {15'h0000, irq});
            rreg(`SBG_OFS_STAT, k ? 8'h40 : 8'h80);
            wreg(`SBG_OFS_BDH, k ? 8'h40 : 8'h80);
            wreg(`SBG_OFS_BDL, 8'h04);
            @(negedge clk_sys);
            chk("irq raised", 16'h0001, {15'h0000, irq});
            wreg(`SBG_OFS_STAT, k ? 8'h40 : 8'h80);
            @(negedge clk_sys);
            chk("irq cleared", 16'h0000, {15'h0000, irq});
        end
        // break event and its clear in one cycle: the event wins
        @(posedge clk_sys);
        req[0] <= 1'b1;
        @(posedge clk_sys);
        req[0] <= 1'b0;
        wr <= 1'b1;
        addr <= `SBG_OFS_STAT;
        wdata <= 8'h80;
        @(posedge clk_sys);
        wr <= 1'b0;
        rreg(`SBG_OFS_STAT, 8'h80);
        wreg(`SBG_OFS_STAT, 8'h80);
        wreg(`SBG_OFS_BDH, 8'h00);
        wreg(`SBG_OFS_BDL, 8'h04);
        repeat (20) @(negedge clk_sys);
        chk("unarmed", 16'h0000, {ticks[14:0], active});
        wreg(`SBG_OFS_BDH, 8'h01);
        wreg(`SBG_OFS_CTRL, 8'h04);
        @(negedge clk_sys);
        chk("armed", 16'h0003, {14'h0000, rx_en, active});
        per(1'b0, 16'd4);
        wreg(`SBG_OFS_BDL, 8'h02);
        per(1'b0, 16'd258);
        wreg(`SBG_OFS_BDH, 8'h00);
        wreg(`SBG_OFS_BDL, 8'h03);
        per(1'b0, 16'd3);
        per(1'b1, 16'd48);
        wreg(`SBG_OFS_BDL, 8'h01);
        per(1'b0, 16'd1);
        wreg(`SBG_OFS_BDH, 8'h1f);
        wreg(`SBG_OFS_BDL, 8'hff);
        per(1'b0, 16'd8191);
        wreg(`SBG_OFS_BDH, 8'h00);
        wreg(`SBG_OFS_BDL, 8'h00);
        repeat (3) @(negedge clk_sys);
        t0 = ticks;
        repeat (50) @(negedge clk_sys);
        chk("stopped", 16'h0000, {14'h0000, ticks != t0, active});
        wreg(`SBG_OFS_BDL, 8'h02);
        per(1'b0, 16'd2);
        wreg(`SBG_OFS_CTRL, 8'h08);
        @(negedge clk_sys);
        chk("tx enable", 16'h0001, {15'h0000, tx_en});
        // reset in mid-run returns everything to the idle state
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        @(negedge clk_sys);
        chk("reset outputs", 16'h0000, {11'h000, rx_en, tx_en, tick, active, irq});
        rreg(`SBG_OFS_BDL, 8'h04);
        repeat (10) @(negedge clk_sys);
        chk("idle after reset", 16'h0000, {15'h0000, active});
        report_and_stop;
    end
endmodule : tb
